// *** hdl/ddsc_pkg.sv ***
// ddsc_pkg: shared constants for the dual dac serial command port
package ddsc_pkg;

   // =========================================================
   // word layout
   localparam int WORD_BITS  = 24;
   localparam int CMD_MSB    = 23;
   localparam int CMD_LSB    = 20;
   localparam int ADDR_MSB   = 19;
   localparam int ADDR_LSB   = 16;
   localparam int DATA_BITS  = 16;
   localparam int PAD_BITS   = 8;
   localparam int CNT_BITS   = 6;

   // =========================================================
   // command and address codes
   localparam logic [3:0] CMD_WRITE      = 4'h0;
   localparam logic [3:0] CMD_UPDATE     = 4'h1;
   localparam logic [3:0] CMD_WRITE_UALL = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD  = 4'h3;
   localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
   localparam logic [3:0] CMD_NOP        = 4'hf;
   localparam logic [3:0] ADDR_A         = 4'h0;
   localparam logic [3:0] ADDR_B         = 4'h1;
   localparam logic [3:0] ADDR_ALL       = 4'hf;

   // =========================================================
   // power-up delays and clock periods, in nanoseconds, and the wake timer width
   localparam int T_WAKE_ONE_NS    = 5000;
   localparam int T_WAKE_BOTH5_NS  = 12000;
   localparam int T_WAKE_BOTH3_NS  = 30000;
   localparam int LINK_PERIOD_NS   = 160;
   localparam int MCLK_PERIOD_NS   = 8;
   localparam int WAKE_CNT_BITS    = 16;

   // =========================================================
   // host states
   typedef enum logic [1:0] {DDSC_IDLE, DDSC_SHIFT, DDSC_END} ddsc_state_t;

endpackage : ddsc_pkg

// *** hdl/ddsc_if.sv ***
// ddsc_if: three-wire serial link between host and dac
interface ddsc_if;
   logic select_load_strobe;
   logic sclk;
   logic serial_in_pin;

   modport host (output select_load_strobe, output sclk, output serial_in_pin);
   modport dev  (input select_load_strobe, input sclk, input serial_in_pin);
endinterface : ddsc_if

// *** hdl/ddsc_dac.sv ***
// ddsc_dac: device end, command shifter, register pairs and power-down state
module ddsc_dac
#(
   parameter int RES_BITS = 16,
   parameter bit SUPPLY_5V = 1'b1
)
(
   // link, clocked by the host serial clock
   ddsc_if.dev                    link,
   // core clock and reset
   input  wire logic              mclk,
   input  wire logic              nrst,
   // active codes and channel status
   output logic [RES_BITS-1:0]    output_channel_a,
   output logic [RES_BITS-1:0]    output_channel_b,
   output logic [1:0]             powered_down,
   output logic [1:0]             settling
);
   import ddsc_pkg::*;

   localparam int WAKE_ONE  = (T_WAKE_ONE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int WAKE_BOTH = ((SUPPLY_5V ? T_WAKE_BOTH5_NS : T_WAKE_BOTH3_NS)
                               + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   if (RES_BITS != 16 && RES_BITS != 14 && RES_BITS != 12)
   begin : g_bad_res
      $error("ddsc_dac: resolution must be 16, 14 or 12");
   end

   if (WAKE_BOTH >= 2 ** WAKE_CNT_BITS)
   begin : g_bad_wake
      $error("ddsc_dac: wake count does not fit its timer");
   end

   // =========================================================
   // link domain: shifter and word capture
   logic [WORD_BITS-1:0] shift_r;
   logic [WORD_BITS-1:0] word_r;

   // pad bits simply fall off the top of the 24-bit shifter
   always_ff @(posedge link.sclk)
   begin
      if (!link.select_load_strobe)
         shift_r <= {shift_r[WORD_BITS-2:0], link.serial_in_pin};
   end

   // strobe rise latches the word; sclk may be idle after that
   always_ff @(posedge link.select_load_strobe)
   begin
      word_r <= shift_r;
   end

   // =========================================================
   // crossing: strobe into mclk, captured word held stable meanwhile
   logic       stb_s1_r;
   logic       stb_s2_r;
   logic       stb_s3_r;
   logic       exec;

   // reset to the idle high level, so no false rise follows reset
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         stb_s1_r <= 1'b1;
         stb_s2_r <= 1'b1;
         stb_s3_r <= 1'b1;
      end
      else
      begin
         stb_s1_r <= link.select_load_strobe;
         stb_s2_r <= stb_s1_r;
         stb_s3_r <= stb_s2_r;
      end
   end
   // limitation: strobe must stay high a few mclk cycles between words
   assign exec = stb_s2_r && !stb_s3_r;

   // =========================================================
   // command decode
   logic [3:0]          cmd;
   logic [3:0]          addr;
   logic [1:0]          sel;
   logic                do_write;
   logic                do_upd;
   logic                do_uall;
   logic                do_pd;
   logic [RES_BITS-1:0] code;

   function automatic logic [1:0] chan_sel(input logic [3:0] a);
      case (a)
         ADDR_A:   chan_sel = 2'h1;
         ADDR_B:   chan_sel = 2'h2;
         ADDR_ALL: chan_sel = 2'h3;
         default:  chan_sel = 2'h0;
      endcase
   endfunction : chan_sel

   always_comb
   begin
      cmd      = word_r[CMD_MSB:CMD_LSB];
      addr     = word_r[ADDR_MSB:ADDR_LSB];
      sel      = chan_sel(addr);
      code     = word_r[DATA_BITS-1 -: RES_BITS];
      do_write = exec && (cmd == CMD_WRITE || cmd == CMD_WRITE_UALL
                          || cmd == CMD_WRITE_UPD);
      do_upd   = exec && (cmd == CMD_UPDATE || cmd == CMD_WRITE_UPD);
      do_uall  = exec && (cmd == CMD_WRITE_UALL);
      do_pd    = exec && (cmd == CMD_POWER_DOWN);
   end

   // =========================================================
   // per-channel registers
   logic [RES_BITS-1:0] in_r  [2];
   logic [RES_BITS-1:0] act_r [2];
   logic [1:0]          pd_r;
   logic [1:0]          upd_ch;
   logic [1:0]          wake_ch;
   logic                both_down;
   logic [WAKE_CNT_BITS-1:0] wake_r [2];

   assign both_down = &pd_r;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ch
         assign upd_ch[g]  = (do_upd && sel[g]) || do_uall;
         assign wake_ch[g] = upd_ch[g] && pd_r[g];

         always_ff @(posedge mclk)
         begin
            if (!nrst)
               in_r[g] <= '0;
            else if (do_write && sel[g])
               in_r[g] <= code;
         end

         // write-and-update copies the freshly shifted code
         always_ff @(posedge mclk)
         begin
            if (!nrst)
               act_r[g] <= '0;
            else if (upd_ch[g])
               act_r[g] <= (do_write && sel[g]) ? code : in_r[g];
         end

         // power-down leaves both register sets alone
         always_ff @(posedge mclk)
         begin
            if (!nrst)
               pd_r[g] <= 1'b0;
            else if (upd_ch[g])
               pd_r[g] <= 1'b0;
            else if (do_pd && sel[g])
               pd_r[g] <= 1'b1;
         end

         always_ff @(posedge mclk)
         begin
            if (!nrst)
               wake_r[g] <= '0;
            else if (wake_ch[g])
               wake_r[g] <= both_down ? WAKE_CNT_BITS'(WAKE_BOTH)
                                      : WAKE_CNT_BITS'(WAKE_ONE);
            else if (wake_r[g] != '0)
               wake_r[g] <= wake_r[g] - 1'b1;
         end
      end
   endgenerate

   // =========================================================
   // registered outputs
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         output_channel_a <= '0;
         output_channel_b <= '0;
         powered_down     <= 2'h0;
         settling         <= 2'h0;
      end
      else
      begin
         // a powered-down channel shows zero, as its pin is pulled down
         output_channel_a <= pd_r[0] ? '0 : act_r[0];
         output_channel_b <= pd_r[1] ? '0 : act_r[1];
         powered_down     <= pd_r;
         settling         <= {wake_r[1] != '0, wake_r[0] != '0};
      end
   end

endmodule : ddsc_dac

// *** hdl/ddsc_host.sv ***
// ddsc_host: host end, serialises one command word per request
module ddsc_host
#(
   parameter int SCK_DIV = 10
)
(
   // link
   ddsc_if.host               link,
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          nrst,
   // request
   input  wire logic          req,
   input  wire logic          long_word,
   input  wire logic [3:0]    command_field,
   input  wire logic [3:0]    channel_address_field,
   input  wire logic [15:0]   data_word,
   // status
   output logic               busy,
   output logic               done
);
   import ddsc_pkg::*;

   // divider counter is 8 bits wide, so half a period is at most 256
   if (SCK_DIV < 2 || SCK_DIV % 2 != 0 || SCK_DIV > 512)
   begin : g_bad_div
      $error("ddsc_host: SCK_DIV must be even, from 2 to 512");
   end

   localparam int HALF = SCK_DIV / 2;

   ddsc_state_t               st_r;
   logic [31:0]               sh_r;
   logic [CNT_BITS-1:0]       bits_r;
   logic [7:0]                div_r;
   logic                      sck_r;
   logic                      cs_r;

   assign link.select_load_strobe = cs_r;
   assign link.sclk               = sck_r;
   assign link.serial_in_pin      = sh_r[31];

   // data changes on falling sclk, device samples on rising
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         st_r   <= DDSC_IDLE;
         sh_r   <= '0;
         bits_r <= '0;
         div_r  <= '0;
         sck_r  <= 1'b0;
         cs_r   <= 1'b1;
         busy   <= 1'b0;
         done   <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (st_r)
            DDSC_IDLE:
            begin
               if (req)
               begin
                  sh_r   <= long_word ? {PAD_BITS'(0), command_field,
                                         channel_address_field, data_word}
                                      : {command_field, channel_address_field,
                                         data_word, PAD_BITS'(0)};
                  bits_r <= long_word ? CNT_BITS'(WORD_BITS + PAD_BITS)
                                      : CNT_BITS'(WORD_BITS);
                  cs_r   <= 1'b0;
                  busy   <= 1'b1;
                  div_r  <= '0;
                  st_r   <= DDSC_SHIFT;
               end
            end
            DDSC_SHIFT:
            begin
               if (div_r == 8'(HALF - 1))
               begin
                  div_r <= '0;
                  sck_r <= ~sck_r;
                  if (sck_r)
                  begin
                     sh_r   <= {sh_r[30:0], 1'b0};
                     if (bits_r == CNT_BITS'(1))
                        st_r <= DDSC_END;
                     bits_r <= bits_r - 1'b1;
                  end
               end
               else
                  div_r <= div_r + 1'b1;
            end
            DDSC_END:
            begin
               // strobe rises half a period after the last falling edge
               if (div_r == 8'(HALF - 1))
               begin
                  cs_r <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  st_r <= DDSC_IDLE;
               end
               else
                  div_r <= div_r + 1'b1;
            end
            default: st_r <= DDSC_IDLE;
         endcase
      end
   end

endmodule : ddsc_host

// *** dv/ddsc_monitor.sv ***
// ddsc_monitor: wire-level checks on the three-wire command link
module ddsc_monitor
#(
   parameter int SCK_DIV = 10
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // link
   input wire logic select_load_strobe,
   input wire logic sclk,
   input wire logic serial_in_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FRAME_MIN = 20 * SCK_DIV;
   localparam int FRAME_MAX = 36 * SCK_DIV;
   // =============================================
   // helper: bit count and word, seen from the core clock
   logic        sclk_r;
   logic [5:0]  cnt_r;
   logic [31:0] word_r;
   wire logic   sclk_rise = sclk & ~sclk_r;
   always_ff @(posedge mclk) sclk_r <= sclk;
   always_ff @(posedge mclk)
   begin
      if (!nrst || select_load_strobe)
         cnt_r <= 6'h00;
      else if (sclk_rise)
         cnt_r <= cnt_r + 6'h01;
   end
   // no reset: only read at a strobe rise, after a full word
   always_ff @(posedge mclk)
   begin
      if (!select_load_strobe && sclk_rise)
         word_r <= {word_r[30:0], serial_in_pin};
   end
   // =============================================
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_load; $rose(select_load_strobe); endsequence
   sequence s_open; $fell(select_load_strobe); endsequence
   property p_idle; select_load_strobe |-> !sclk; endproperty
   property p_len; s_load |-> cnt_r == 6'h18 || cnt_r == 6'h20; endproperty
   property p_pad; s_load |-> cnt_r != 6'h20 || word_r[31:24] == 8'h00; endproperty
   property p_cmd; s_load |-> word_r[23:20] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
   endproperty
   property p_addr; s_load |-> word_r[19:16] inside {4'h0, 4'h1, 4'hf}; endproperty
   property p_gap; s_load |=> select_load_strobe [*4]; endproperty
   property p_lead; s_open |-> !sclk [*2]; endproperty
   property p_frame; s_open |-> ##[FRAME_MIN:FRAME_MAX] s_load; endproperty
   property p_hold; sclk |-> $stable(serial_in_pin); endproperty
   a_idle: assert property (p_idle) else $error("clock moved outside frame");
   a_len: assert property (p_len) else $error("word length wrong");
   a_pad: assert property (p_pad) else $error("pad bits not zero");
   a_cmd: assert property (p_cmd) else $error("reserved command");
   a_addr: assert property (p_addr) else $error("reserved address");
   a_gap: assert property (p_gap) else $error("strobe high too short");
   a_lead: assert property (p_lead) else $error("clock too soon");
   a_frame: assert property (p_frame) else $error("frame length off");
   a_hold: assert property (p_hold) else $error("data moved, clock high");
endmodule : ddsc_monitor

// *** dv/dual_dac_serial_command_port_test.sv ***
// dual_dac_serial_command_port_test: host and dac back to back, command sequences
module dual_dac_serial_command_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ddsc_pkg::*;
   `define CHK(a, e) \
   begin \
      compares++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("Error at %0t: got %h exp %h", $time, a, e); \
      end \
   end
   logic        mclk;
   logic        nrst;
   logic        req;
   logic        long_word;
   logic [3:0]  command_field;
   logic [3:0]  channel_address_field;
   logic [15:0] data_word;
   logic        busy;
   logic        done;
   logic [15:0] output_channel_a;
   logic [15:0] output_channel_b;
   logic [1:0]  powered_down;
   logic [1:0]  settling;
   int          failures = 0;
   int          compares = 0;
   ddsc_if link();
   // short divider keeps frames brief
   ddsc_host #(.SCK_DIV(4)) u_ddsc_host (.link(link), .mclk(mclk), .nrst(nrst),
      .req(req), .long_word(long_word), .command_field(command_field),
      .channel_address_field(channel_address_field), .data_word(data_word),
      .busy(busy), .done(done));
   ddsc_dac #(.RES_BITS(16), .SUPPLY_5V(1'b1)) u_ddsc_dac (.link(link), .mclk(mclk),
      .nrst(nrst), .output_channel_a(output_channel_a),
      .output_channel_b(output_channel_b), .powered_down(powered_down),
      .settling(settling));
   ddsc_monitor #(.SCK_DIV(4)) u_ddsc_monitor (.mclk(mclk), .nrst(nrst),
      .select_load_strobe(link.select_load_strobe), .sclk(link.sclk),
      .serial_in_pin(link.serial_in_pin));
   // =============================================
   // tasks
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                       input logic lw);
      int n;
      @(posedge mclk);
      #1;
      req = 1'b1;
      command_field = c;
      channel_address_field = a;
      data_word = d;
      long_word = lw;
      @(posedge mclk);
      #1;
      req = 1'b0;
      `CHK(busy, 1'b1)
      n = 0;
      while (done !== 1'b1 && n < 1000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(done, 1'b1)
      `CHK(busy, 1'b0)
      // execution lands a few core cycles after the strobe rise
      repeat (8) @(posedge mclk);
      #1;
   endtask : send
   task automatic expect_out(input logic [15:0] a, input logic [15:0] b,
                             input logic [1:0] p);
      `CHK(output_channel_a, a)
      `CHK(output_channel_b, b)
      `CHK(powered_down, p)
   endtask : expect_out
   task automatic wait_settle(input int n, input logic [1:0] e);
      repeat (n) @(posedge mclk);
      #1;
      `CHK(settling, e)
   endtask : wait_settle
   // =============================================
   // clock, watchdog, sequence
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      conclude();
   end
   initial
   begin
      nrst = 1'b0;
      req = 1'b0;
      long_word = 1'b0;
      command_field = CMD_NOP;
      channel_address_field = ADDR_ALL;
      data_word = 16'h0000;
      repeat (4) @(posedge mclk);
      #1;
      nrst = 1'b1;
      expect_out(16'h0000, 16'h0000, 2'b00);
      send(CMD_NOP, ADDR_ALL, 16'hffff, 1'b0);
      expect_out(16'h0000, 16'h0000, 2'b00);
      send(CMD_WRITE, ADDR_A, 16'h1234, 1'b0);
      expect_out(16'h0000, 16'h0000, 2'b00);
      send(CMD_UPDATE, ADDR_A, 16'h9999, 1'b0);
      expect_out(16'h1234, 16'h0000, 2'b00);
      send(CMD_WRITE_UPD, ADDR_B, 16'habcd, 1'b1);
      expect_out(16'h1234, 16'habcd, 2'b00);
      send(CMD_POWER_DOWN, ADDR_ALL, 16'h5a5a, 1'b0);
      expect_out(16'h0000, 16'h0000, 2'b11);
      send(CMD_WRITE, ADDR_A, 16'h5555, 1'b1);
      expect_out(16'h0000, 16'h0000, 2'b11);
      send(CMD_WRITE_UALL, ADDR_B, 16'h7777, 1'b0);
      expect_out(16'h5555, 16'h7777, 2'b00);
      wait_settle(1380, 2'b11);
      wait_settle(160, 2'b00);
      send(CMD_POWER_DOWN, ADDR_A, 16'h0000, 1'b0);
      expect_out(16'h0000, 16'h7777, 2'b01);
      send(CMD_UPDATE, ADDR_A, 16'h0000, 1'b0);
      expect_out(16'h5555, 16'h7777, 2'b00);
      wait_settle(560, 2'b01);
      wait_settle(120, 2'b00);
      send(CMD_WRITE_UPD, ADDR_ALL, 16'h4321, 1'b0);
      expect_out(16'h4321, 16'h4321, 2'b00);
      conclude();
   end
endmodule : dual_dac_serial_command_port_test
